// File: pkg/timer2_map.svh
// Register offsets, field positions, reset values and mode codes
// for the 8-bit timer core. Assumes a 32-bit APB bus, byte addressed.
//
// Functional notes
// - Counter and both compare registers are 8 bits
// - Each flag visible, each gated by mask
// - No selected source means counter stays still
// - Both compares checked on every timer tick
// - Compare match sets its channel flag
// - Compare results drive PWM or frequency output
// - Timer runs only while power-down bit clear
// - Channel B output internal only, no pin
// - Bottom signalled when counter equals zero
// - Maximum signalled when counter equals 255
// - Top is 255 or compare A per mode
// - Async bit clear: tick from I/O clock
// - Async bit set: crystal or meter pin clock
// - Ten-bit prescaler divides selected source
// - Overflow, compare A, compare B interrupt sources
// - Clear-on-compare mode gives auto-reload period
// - Can count from external 32 kHz crystal
// - Mode codes 0,1,2,3,5,7; 4,6 reserved
// - Software counter write beats clear or count
// - Source zero stops counter; still accessible
// - Normal mode overflow flag set on wrap
`ifndef TIMER2_MAP_SVH
`define TIMER2_MAP_SVH

`define T2_OFF_CTRL     8'h00
`define T2_OFF_COUNT    8'h04
`define T2_OFF_CMPA     8'h08
`define T2_OFF_CMPB     8'h0c
`define T2_OFF_FLAG     8'h10
`define T2_OFF_MASK     8'h14
`define T2_OFF_ASYNC    8'h18
`define T2_OFF_POWER    8'h1c
`define T2_OFF_STATUS   8'h20

`define T2_CTRL_W       10
`define T2_ASYNC_SEL    0
`define T2_ASYNC_METER  1
`define T2_POWER_DOWN   0
`define T2_ST_A_OUT     0
`define T2_ST_B_OUT     1
`define T2_ST_DOWN      2

`define T2_RST_BYTE     8'h00
`define T2_RST_CTRL     10'h000
`define T2_MAX          8'hff
`define T2_BOTTOM       8'h00

`define T2_WGM_NORMAL   3'h0
`define T2_WGM_PC_MAX   3'h1
`define T2_WGM_CTC      3'h2
`define T2_WGM_FAST_MAX 3'h3
`define T2_WGM_PC_TOP   3'h5
`define T2_WGM_FAST_TOP 3'h7

`define T2_COM_TOGGLE   2'h1
`define T2_COM_CLEAR    2'h2
`define T2_COM_SET      2'h3

`define T2_PS_MASK_1    10'h000
`define T2_PS_MASK_8    10'h007
`define T2_PS_MASK_32   10'h01f
`define T2_PS_MASK_64   10'h03f
`define T2_PS_MASK_128  10'h07f
`define T2_PS_MASK_256  10'h0ff
`define T2_PS_MASK_1024 10'h3ff

`endif

// File: pkg/timer2_pkg.sv
// Types shared by the timer core and its prescaler.
// Assumes the constants header is included by each user.
package timer2_pkg;

  // Control register layout, high bits first in the word
  typedef struct packed {
    logic [1:0] com_b;
    logic [1:0] com_a;
    logic [2:0] waveform_mode_sel;
    logic [2:0] clock_source_sel;
  } ctrl_type;

  // One bit per interrupt source
  typedef struct packed {
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } irq_type;

endpackage : timer2_pkg

// File: rtl/timer2_prescaler.sv
// Ten-bit prescaler forming the timer tick from a source pulse.
// Assumes src_pulse is a one-cycle enable on the pclk domain.
`timescale 1ns/10ps
`include "timer2_map.svh"

module timer2_prescaler
(
  input  wire logic       pclk,      // System clock
  input  wire logic       presetn,   // Async reset, active low
  input  wire logic       src_pulse, // One pulse per source edge
  input  wire logic       clear,     // Hold prescaler at zero
  input  wire logic [2:0] sel,       // Clock source select
  output logic            tick       // Timer tick enable
);
  import timer2_pkg::*;

  logic [9:0] count;

  // Tap mask: the tick fires when all masked low bits are ones
  function automatic logic [9:0] tap_mask(input logic [2:0] s);
    case (s)
      3'h2:    tap_mask = `T2_PS_MASK_8;
      3'h3:    tap_mask = `T2_PS_MASK_32;
      3'h4:    tap_mask = `T2_PS_MASK_64;
      3'h5:    tap_mask = `T2_PS_MASK_128;
      3'h6:    tap_mask = `T2_PS_MASK_256;
      3'h7:    tap_mask = `T2_PS_MASK_1024;
      default: tap_mask = `T2_PS_MASK_1;
    endcase
  endfunction : tap_mask

  // Free running, so the first tick after enabling may come early
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 10'h000;
    else if (clear)
      count <= 10'h000;
    else if (src_pulse)
      count <= count + 10'h001;
  end

  // Zero select gives no tick at all
  assign tick = src_pulse && !clear && (sel != 3'h0) &&
                ((count & tap_mask(sel)) == tap_mask(sel));

endmodule : timer2_prescaler

// File: rtl/timer2_core.sv
// Eight-bit timer core: counter, two buffered compares, flags,
// clock select and APB register slave.
// Assumes APB from the pclk domain; crystal and meter pins are async.
`timescale 1ns/10ps
`include "timer2_map.svh"

module timer2_core
(
  input  wire logic          pclk,            // System clock, 40 MHz
  input  wire logic          presetn,         // Async reset, active low
  input  wire logic          psel,            // APB select
  input  wire logic          penable,         // APB enable
  input  wire logic          pwrite,          // APB write
  input  wire logic [7:0]    paddr,           // APB byte address
  input  wire logic [31:0]   pwdata,          // APB write data
  output logic      [31:0]   prdata,          // APB read data
  output logic               pready,          // APB ready
  output logic               pslverr,         // APB error
  input  wire logic          osc_pin_in,      // Watch crystal clock in
  output logic               osc_pin_out,     // Oscillator amp enable
  input  wire logic          meter_clock_pin, // Meter-reading clock in
  output logic               compare_a_out,   // Channel A waveform
  output logic               compare_a_oe,    // Channel A pin enable
  output timer2_pkg::irq_type irq_req,        // Masked requests
  input  wire timer2_pkg::irq_type irq_ack    // Service pulses
);
  import timer2_pkg::*;

  ctrl_type   ctrl;
  irq_type    irq_flag_reg, irq_mask_reg, flag_set;
  logic [7:0] counter_value, compare_a_value, compare_b_value;
  logic [7:0] cmp_a_act, cmp_b_act, top, next_count;
  logic [1:0] pin_s1, pin_s2, pin_s3, pin_rise;
  logic [2:0] wgm;
  logic       next_down, count_down, async_clock_select, meter_select;
  logic       timer_power_down, compare_a_lvl, compare_b_lvl;
  logic       src_pulse, tick, run, wr, rd_hit;
  logic       at_bottom, at_max, at_top, mode_fast, mode_pc, top_is_a;
  logic       match_a, match_b, wrap, cnt_wr;

  // Address decode used by both write enable and error answer
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `T2_OFF_CTRL, `T2_OFF_COUNT, `T2_OFF_CMPA, `T2_OFF_CMPB,
      `T2_OFF_FLAG, `T2_OFF_MASK, `T2_OFF_ASYNC, `T2_OFF_POWER,
      `T2_OFF_STATUS: mapped = 1'b1;
      default:        mapped = 1'b0;
    endcase
  endfunction : mapped

  // Next waveform level for one channel
  function automatic logic wave_next(
    input logic       fast, pc, tgl_ok,
    input logic [1:0] com,
    input logic       lvl, match, wrp, down);
    logic r;
    r = lvl;
    if (fast || pc)
    begin
      if (match && com == `T2_COM_TOGGLE && tgl_ok)
        r = !lvl;
      else if (match && com == `T2_COM_CLEAR)
        r = pc && down;
      else if (match && com == `T2_COM_SET)
        r = !(pc && down);
      if (fast && wrp && com == `T2_COM_CLEAR)
        r = 1'b1;
      else if (fast && wrp && com == `T2_COM_SET)
        r = 1'b0;
    end
    else if (match)
    begin
      case (com)
        `T2_COM_TOGGLE: r = !lvl;
        `T2_COM_CLEAR:  r = 1'b0;
        `T2_COM_SET:    r = 1'b1;
        default:        r = lvl;
      endcase
    end
    wave_next = r;
  endfunction : wave_next

  // APB: zero wait states, error on unmapped address
  assign pready  = 1'b1;
  assign rd_hit  = mapped(paddr);
  assign pslverr = psel && penable && !rd_hit;
  assign wr      = psel && penable && pwrite && rd_hit;

  // Two flops per pin, third flop only for the edge detector
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
        end
        else
        begin
          pin_s1[gi] <= (gi == 0) ? osc_pin_in : meter_clock_pin;
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
        end
      end
      assign pin_rise[gi] = pin_s2[gi] && !pin_s3[gi];
    end
  endgenerate

  // Source: I/O clock by default, else crystal or meter pin edges
  assign src_pulse = !async_clock_select ? 1'b1 :
                     (meter_select ? pin_rise[1] : pin_rise[0]);

  timer2_prescaler u_prescaler
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .src_pulse (src_pulse),
    .clear     (timer_power_down),
    .sel       (ctrl.clock_source_sel),
    .tick      (tick)
  );

  // Power-down blocks every tick
  assign run = tick && !timer_power_down;

  // Mode decode and top selection
  assign wgm       = ctrl.waveform_mode_sel;
  assign mode_fast = (wgm == `T2_WGM_FAST_MAX) || (wgm == `T2_WGM_FAST_TOP);
  assign mode_pc   = (wgm == `T2_WGM_PC_MAX) || (wgm == `T2_WGM_PC_TOP);
  assign top_is_a  = (wgm == `T2_WGM_CTC) || (wgm == `T2_WGM_PC_TOP) ||
                     (wgm == `T2_WGM_FAST_TOP);
  assign top       = top_is_a ? cmp_a_act : `T2_MAX;
  assign at_bottom = (counter_value == `T2_BOTTOM);
  assign at_max    = (counter_value == `T2_MAX);
  assign at_top    = (counter_value == top);
  assign match_a   = run && (counter_value == cmp_a_act);
  assign match_b   = run && (counter_value == cmp_b_act);
  assign wrap      = run && at_top;

  // Count sequence; reserved codes 4 and 6 count like normal mode
  always_comb
  begin
    next_count = counter_value;
    next_down  = count_down;
    if (mode_pc)
    begin
      if (!count_down && at_top)
        next_down = 1'b1;
      else if (count_down && at_bottom)
        next_down = 1'b0;
      next_count = next_down ? counter_value - 8'h01
                             : counter_value + 8'h01;
    end
    else if (top_is_a || mode_fast)
      next_count = at_top ? `T2_BOTTOM : counter_value + 8'h01;
    else
      next_count = counter_value + 8'h01;
  end

  // Counter: a software write beats any count or clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      counter_value <= `T2_RST_BYTE;
      count_down    <= 1'b0;
    end
    else if (wr && paddr == `T2_OFF_COUNT)
      counter_value <= pwdata[7:0];
    else if (run)
    begin
      counter_value <= next_count;
      count_down    <= next_down;
    end
  end

  // Control registers written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl               <= `T2_RST_CTRL;
      compare_a_value    <= `T2_RST_BYTE;
      compare_b_value    <= `T2_RST_BYTE;
      irq_mask_reg       <= 3'h0;
      async_clock_select <= 1'b0;
      meter_select       <= 1'b0;
      timer_power_down   <= 1'b0;
    end
    else if (wr)
    begin
      case (paddr)
        `T2_OFF_CTRL:  ctrl <= ctrl_type'(pwdata[`T2_CTRL_W-1:0]);
        `T2_OFF_CMPA:  compare_a_value <= pwdata[7:0];
        `T2_OFF_CMPB:  compare_b_value <= pwdata[7:0];
        `T2_OFF_MASK:  irq_mask_reg <= irq_type'(pwdata[2:0]);
        `T2_OFF_ASYNC:
        begin
          async_clock_select <= pwdata[`T2_ASYNC_SEL];
          meter_select       <= pwdata[`T2_ASYNC_METER];
        end
        `T2_OFF_POWER: timer_power_down <= pwdata[`T2_POWER_DOWN];
        default:       ctrl <= ctrl;
      endcase
    end
  end

  // Compare buffers: immediate in non-PWM modes, at top in PWM modes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_a_act <= `T2_RST_BYTE;
      cmp_b_act <= `T2_RST_BYTE;
    end
    else if (!(mode_fast || mode_pc) || wrap)
    begin
      cmp_a_act <= compare_a_value;
      cmp_b_act <= compare_b_value;
    end
  end

  // Overflow event position depends on the mode
  always_comb
  begin
    flag_set.cmp_a = match_a;
    flag_set.cmp_b = match_b;
    if (mode_pc)
      flag_set.ovf = run && count_down && at_bottom;
    else if (wgm == `T2_WGM_FAST_TOP)
      flag_set.ovf = wrap;
    else
      flag_set.ovf = run && at_max;
  end

  // Flags: a hardware set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_flag_reg <= 3'h0;
    else
      irq_flag_reg <= flag_set | (irq_flag_reg & ~irq_ack &
                      ~((wr && paddr == `T2_OFF_FLAG) ?
                        irq_type'(pwdata[2:0]) : irq_type'(3'h0)));
  end

  assign irq_req = irq_flag_reg & irq_mask_reg;

  // Waveform levels; channel B never reaches a pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compare_a_lvl <= 1'b0;
      compare_b_lvl <= 1'b0;
    end
    else
    begin
      compare_a_lvl <= wave_next(mode_fast, mode_pc, top_is_a, ctrl.com_a,
                                 compare_a_lvl, match_a, wrap,
                                 count_down);
      compare_b_lvl <= wave_next(mode_fast, mode_pc, 1'b0, ctrl.com_b,
                                 compare_b_lvl, match_b, wrap,
                                 count_down);
    end
  end

  // Pin drivers come from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compare_a_out <= 1'b0;
      compare_a_oe  <= 1'b0;
      osc_pin_out   <= 1'b0;
    end
    else
    begin
      compare_a_out <= compare_a_lvl;
      compare_a_oe  <= (ctrl.com_a != 2'h0);
      osc_pin_out   <= async_clock_select && !meter_select;
    end
  end

  // Read mux; unused upper bits read as zero
  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      `T2_OFF_CTRL:   prdata[`T2_CTRL_W-1:0] = ctrl;
      `T2_OFF_COUNT:  prdata[7:0] = counter_value;
      `T2_OFF_CMPA:   prdata[7:0] = compare_a_value;
      `T2_OFF_CMPB:   prdata[7:0] = compare_b_value;
      `T2_OFF_FLAG:   prdata[2:0] = irq_flag_reg;
      `T2_OFF_MASK:   prdata[2:0] = irq_mask_reg;
      `T2_OFF_ASYNC:  prdata[1:0] = {meter_select, async_clock_select};
      `T2_OFF_POWER:  prdata[`T2_POWER_DOWN] = timer_power_down;
      `T2_OFF_STATUS:
      begin
        prdata[`T2_ST_A_OUT] = compare_a_lvl;
        prdata[`T2_ST_B_OUT] = compare_b_lvl;
        prdata[`T2_ST_DOWN]  = count_down;
      end
      default:        prdata = 32'h0000_0000;
    endcase
  end

  // Checks
  assign cnt_wr = wr && paddr == `T2_OFF_COUNT;

  property p_stop_hold;
    @(posedge pclk) disable iff (!presetn)
    (ctrl.clock_source_sel == 3'h0 && !cnt_wr) |=>
      $stable(counter_value);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("counter moved with no clock source");

  property p_power_hold;
    @(posedge pclk) disable iff (!presetn)
    (timer_power_down && !cnt_wr)[*2] |-> $stable(counter_value);
  endproperty
  a_power_hold: assert property (p_power_hold)
    else $error("counter moved while powered down");

  property p_write_wins;
    @(posedge pclk) disable iff (!presetn)
    cnt_wr |=> counter_value == $past(pwdata[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("counter write lost");

  property p_normal_wrap;
    @(posedge pclk) disable iff (!presetn)
    (run && wgm == `T2_WGM_NORMAL && at_max && !cnt_wr) |=>
      irq_flag_reg.ovf && counter_value == 8'h00;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap)
    else $error("overflow flag not set on wrap");

  property p_match_a;
    @(posedge pclk) disable iff (!presetn)
    (run && counter_value == cmp_a_act) |=> irq_flag_reg.cmp_a;
  endproperty
  a_match_a: assert property (p_match_a)
    else $error("compare A flag missed");

  property p_ctc_reload;
    @(posedge pclk) disable iff (!presetn)
    (run && wgm == `T2_WGM_CTC && counter_value == cmp_a_act && !cnt_wr)
      |=> counter_value == 8'h00;
  endproperty
  a_ctc_reload: assert property (p_ctc_reload)
    else $error("clear on compare failed");

  property p_mask_gate;
    @(posedge pclk) disable iff (!presetn)
    $fell(irq_mask_reg.cmp_b) |-> !irq_req.cmp_b;
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("request passed a cleared mask");

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == `T2_OFF_FLAG && pwdata[1] && !match_a) |=>
      !irq_flag_reg.cmp_a;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared by one-write");

endmodule : timer2_core

// File: verif/timer2_core_test.sv
// Self-checking bench for the timer core: APB registers, count modes,
// prescaler, flags and masks, waveform pin and the async sources.
// Assumes the core alone; the bench drives every pin itself.
`timescale 1ns/10ps
`include "timer2_map.svh"

module timer2_core_test;
  import timer2_pkg::*;

  typedef struct
  {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } reg_row_type;

  typedef struct
  {
    logic [2:0] mode;
    int         run;
    logic [7:0] cnt_max;
    logic       ovf;
  } mode_row_type;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc_pin_in;
  logic        osc_pin_out;
  logic        meter_clock_pin;
  logic        compare_a_out;
  logic        compare_a_oe;
  irq_type     irq_req;
  irq_type     irq_ack;
  int          miscompares;
  int          compares;
  logic [31:0] rdata;
  logic        rerr;
  logic [31:0] hold;
  logic        prev;
  int          changes;

  // Write data, readback; row at 0x24 is unmapped and must be refused
  reg_row_type regs [9] = '{
    '{`T2_OFF_CTRL,  32'hffff_fff8, 32'h0000_03f8},
    '{`T2_OFF_COUNT, 32'h0000_01ab, 32'h0000_00ab},
    '{`T2_OFF_CMPA,  32'h0000_01c5, 32'h0000_00c5},
    '{`T2_OFF_CMPB,  32'h0000_013a, 32'h0000_003a},
    '{`T2_OFF_FLAG,  32'h0000_00ff, 32'h0000_0000},
    '{`T2_OFF_MASK,  32'h0000_00ff, 32'h0000_0007},
    '{`T2_OFF_ASYNC, 32'h0000_00ff, 32'h0000_0003},
    '{`T2_OFF_POWER, 32'h0000_00ff, 32'h0000_0001},
    '{8'h24,         32'h0000_00ff, 32'h0000_0000}};

  // Compare A at 0x10, B at 0x08; normal mode last leaves all flags set
  mode_row_type modes [8] = '{
    '{3'h1, 600, 8'hff, 1'b1}, '{3'h2, 300, 8'h10, 1'b0},
    '{3'h3, 300, 8'hff, 1'b1}, '{3'h4, 100, 8'hff, 1'b0},
    '{3'h5, 60,  8'h10, 1'b1}, '{3'h6, 100, 8'hff, 1'b0},
    '{3'h7, 60,  8'h10, 1'b1}, '{3'h0, 300, 8'hff, 1'b1}};

  int divs [6] = '{8, 32, 64, 128, 256, 1024};

  timer2_core u_timer2_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out),
    .meter_clock_pin(meter_clock_pin), .compare_a_out(compare_a_out),
    .compare_a_oe(compare_a_oe), .irq_req(irq_req), .irq_ack(irq_ack));

  // 40 MHz system clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task check(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] rng(input logic [31:0] v, lo, hi);
    return {31'h0, (v >= lo) && (v <= hi)};
  endfunction : rng

  function automatic logic [31:0] mk(input logic [1:0] ca,
                                     input logic [2:0] wm, cs);
    ctrl_type c;
    c = '{com_b: 2'h0, com_a: ca, waveform_mode_sel: wm, clock_source_sel: cs};
    return {22'h0, c};
  endfunction : mk

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask : rd

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task do_reset(input int n);
    presetn <= 1'b0;
    cyc(n);
    presetn <= 1'b1;
  endtask : do_reset

  // Rising edges on a clock pin; crystal and meter lines idle low
  task edges(input logic meter, input int n, input int half);
    repeat (n)
    begin
      if (meter) meter_clock_pin <= 1'b1;
      else osc_pin_in <= 1'b1;
      cyc(half);
      if (meter) meter_clock_pin <= 1'b0;
      else osc_pin_in <= 1'b0;
      cyc(half);
    end
  endtask : edges

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // Watchdog, well beyond the roughly 13500 cycles the run needs
  initial
  begin
    cyc(60000);
    miscompares++;
    $display("Error watchdog expected finish seen timeout");
    end_of_test();
  end

  // Main sequence
  initial
  begin
    miscompares = 0;
    compares = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, osc_pin_in, meter_clock_pin} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    irq_ack = 3'h0;
    do_reset(6);
    foreach (regs[i])
    begin
      rd(regs[i].addr);
      check("reset value", rdata, 32'h0);
      wr(regs[i].addr, regs[i].wdata);
      check("refusal", {31'h0, rerr}, {31'h0, regs[i].addr == 8'h24});
      rd(regs[i].addr);
      check("readback", rdata, regs[i].exp);
    end
    rd(`T2_OFF_COUNT);
    check("stopped count", rdata, 32'hab);
    wr(`T2_OFF_CTRL, 32'h0);
    wr(`T2_OFF_ASYNC, 32'h0);
    wr(`T2_OFF_POWER, 32'h0);
    wr(`T2_OFF_MASK, 32'h0);
    // Each waveform mode run from zero with /1 ticks
    foreach (modes[i])
    begin
      wr(`T2_OFF_CTRL, 32'h0);
      wr(`T2_OFF_CMPA, 32'h10);
      wr(`T2_OFF_CMPB, 32'h08);
      wr(`T2_OFF_COUNT, 32'h0);
      wr(`T2_OFF_FLAG, 32'h7);
      wr(`T2_OFF_CTRL, mk(2'h0, modes[i].mode, 3'h1));
      cyc(modes[i].run);
      wr(`T2_OFF_CTRL, 32'h0);
      rd(`T2_OFF_COUNT);
      check("count top", rng(rdata, 0, modes[i].cnt_max), 32'h1);
      rd(`T2_OFF_FLAG);
      check("mode flags", rdata, {29'h0, 2'h3, modes[i].ovf});
    end
    // Mask gating, one-write clear, zero-write hold, service clear
    @(negedge pclk);
    check("irq masked", {29'h0, irq_req}, 32'h0);
    wr(`T2_OFF_MASK, 32'h2);
    @(negedge pclk);
    check("irq a", {29'h0, irq_req}, 32'h2);
    wr(`T2_OFF_FLAG, 32'h0);
    rd(`T2_OFF_FLAG);
    check("flag zero write", rdata, 32'h7);
    wr(`T2_OFF_FLAG, 32'h1);
    rd(`T2_OFF_FLAG);
    check("flag one write", rdata, 32'h6);
    @(posedge pclk);
    irq_ack <= 3'h2;
    @(posedge pclk);
    irq_ack <= 3'h0;
    rd(`T2_OFF_FLAG);
    check("flag service", rdata, 32'h4);
    wr(`T2_OFF_MASK, 32'h7);
    @(negedge pclk);
    check("irq b", {29'h0, irq_req}, 32'h4);
    // Prescaler taps: four and a half periods give four or five ticks
    foreach (divs[i])
    begin
      wr(`T2_OFF_CTRL, 32'h0);
      wr(`T2_OFF_COUNT, 32'h0);
      wr(`T2_OFF_CTRL, mk(2'h0, 3'h0, 3'(i + 2)));
      cyc(divs[i] * 9 / 2);
      wr(`T2_OFF_CTRL, 32'h0);
      rd(`T2_OFF_COUNT);
      check("prescaled count", rng(rdata, 4, 5), 32'h1);
    end
    // Toggle on match with top 3: one change every four ticks
    wr(`T2_OFF_CMPA, 32'h3);
    wr(`T2_OFF_COUNT, 32'h0);
    wr(`T2_OFF_CTRL, mk(`T2_COM_TOGGLE, `T2_WGM_CTC, 3'h1));
    cyc(10);
    @(negedge pclk);
    check("pin enable", {31'h0, compare_a_oe}, 32'h1);
    prev = compare_a_out;
    changes = 0;
    repeat (80)
    begin
      @(negedge pclk);
      if (compare_a_out !== prev) changes++;
      prev = compare_a_out;
    end
    check("toggles", rng(changes, 19, 21), 32'h1);
    wr(`T2_OFF_CTRL, 32'h0);
    cyc(2);
    check("pin released", {31'h0, compare_a_oe}, 32'h0);
    // Fast PWM to 255, clear at 0x40, set at wrap: 65 of 256 high
    wr(`T2_OFF_CMPA, 32'h40);
    wr(`T2_OFF_CTRL, mk(`T2_COM_CLEAR, `T2_WGM_FAST_MAX, 3'h1));
    cyc(300);
    changes = 0;
    repeat (256)
    begin
      @(negedge pclk);
      if (compare_a_out === 1'b1)
        changes++;
    end
    check("pwm duty", changes, 32'd65);
    // Write while counting wins; power-down freezes the count
    wr(`T2_OFF_CTRL, mk(2'h0, 3'h0, 3'h1));
    wr(`T2_OFF_COUNT, 32'h40);
    rd(`T2_OFF_COUNT);
    check("write priority", rng(rdata, 32'h40, 32'h46), 32'h1);
    wr(`T2_OFF_POWER, 32'h1);
    rd(`T2_OFF_COUNT);
    hold = rdata;
    cyc(20);
    rd(`T2_OFF_COUNT);
    check("powered down", rdata, hold);
    wr(`T2_OFF_POWER, 32'h0);
    rd(`T2_OFF_COUNT);
    check("powered up", {31'h0, rdata !== hold}, 32'h1);
    // Crystal source at 32 kHz, then the meter pin
    wr(`T2_OFF_CTRL, 32'h0);
    wr(`T2_OFF_COUNT, 32'h0);
    wr(`T2_OFF_ASYNC, 32'h1);
    wr(`T2_OFF_CTRL, mk(2'h0, 3'h0, 3'h1));
    @(negedge pclk);
    check("amp enable", {31'h0, osc_pin_out}, 32'h1);
    edges(1'b0, 3, 610);
    wr(`T2_OFF_CTRL, 32'h0);
    rd(`T2_OFF_COUNT);
    check("crystal count", rdata, 32'h3);
    wr(`T2_OFF_ASYNC, 32'h3);
    wr(`T2_OFF_COUNT, 32'h0);
    wr(`T2_OFF_CTRL, mk(2'h0, 3'h0, 3'h1));
    check("amp off", {31'h0, osc_pin_out}, 32'h0);
    edges(1'b1, 2, 8);
    edges(1'b0, 1, 8);
    wr(`T2_OFF_CTRL, 32'h0);
    rd(`T2_OFF_COUNT);
    check("meter count", rdata, 32'h2);
    // Reset in mid-run returns the registers to zero
    wr(`T2_OFF_ASYNC, 32'h0);
    wr(`T2_OFF_CTRL, mk(2'h0, 3'h0, 3'h1));
    cyc(5);
    do_reset(2);
    foreach (regs[i])
    begin
      rd(regs[i].addr);
      check("second reset", rdata, 32'h0);
    end
    end_of_test();
  end

endmodule : timer2_core_test
